// ===== pkg/slbs_pkg.sv
// status LED blink sequencer: timing constants, pattern lengths, modes
// assumes a single 25 MHz clock; all pattern lengths count quarter-second ticks
package slbs_pkg;

   // base clock and tick
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned TICK_MS = 250;
   localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;

   // phase position within a pattern, in ticks
   typedef logic [5:0] slbs_pos_t;

   // pattern timing as printed, in milliseconds, and blink counts
   localparam int unsigned S3_HALF_MS = 250;
   localparam int unsigned RDY_HALF_MS = 1000;
   localparam int unsigned UPD_HALF_MS = 500;
   localparam int unsigned MEM_HALF_MS = 1000;
   localparam int unsigned MEM_PAUSE_MS = 2500;
   localparam int unsigned THERM_HALF_MS = 250;
   localparam int unsigned MEM_BLINKS = 3;
   localparam int unsigned THERM_BLINKS = 16;

   // the same timing converted to ticks
   localparam slbs_pos_t S3_HALF = 6'(S3_HALF_MS / TICK_MS);
   localparam slbs_pos_t RDY_HALF = 6'(RDY_HALF_MS / TICK_MS);
   localparam slbs_pos_t UPD_HALF = 6'(UPD_HALF_MS / TICK_MS);
   localparam slbs_pos_t MEM_HALF = 6'(MEM_HALF_MS / TICK_MS);
   localparam slbs_pos_t MEM_BURST = 6'(2 * MEM_BLINKS * (MEM_HALF_MS / TICK_MS));
   localparam slbs_pos_t MEM_PERIOD = 6'(2 * MEM_BLINKS * (MEM_HALF_MS / TICK_MS) + MEM_PAUSE_MS / TICK_MS);
   localparam slbs_pos_t THERM_HALF = 6'(THERM_HALF_MS / TICK_MS);
   localparam slbs_pos_t THERM_TICKS = 6'(2 * THERM_BLINKS * (THERM_HALF_MS / TICK_MS));

   // displayed condition, one-hot
   typedef enum logic [6:0] {
      M_OFF = 7'h01,
      M_S0 = 7'h02,
      M_S3 = 7'h04,
      M_RDY = 7'h08,
      M_UPD = 7'h10,
      M_MEM = 7'h20,
      M_THERM = 7'h40
   } slbs_mode_t;

endpackage

// ===== pkg/slbs_tick_if.sv
// tick link between the sequencer and its prescaler
// assumes both ends run on the same clock
interface slbs_tick_if;
   logic tick;
   logic restart;

   // prescaler end
   modport gen
   (
      input restart,
      output tick
   );

   // sequencer end
   modport use_tick
   (
      output restart,
      input tick
   );
endinterface

// ===== core/slbs_prescaler.sv
// quarter-second tick prescaler for the status LED sequencer
// assumes restart comes from logic on the same clock
module slbs_prescaler #(
   parameter int unsigned TICK_CYCLES = slbs_pkg::TICK_CYCLES
)
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // tick link
   slbs_tick_if.gen tk
);

   localparam int unsigned CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic next_tick;

   // restart loads one, not zero: the registered tick lags the count by a clock,
   // so this keeps the first phase of a new pattern exactly one tick long
   always_comb
   begin
      next_tick = 1'b0;
      next_cnt = cnt + 1'b1;
      if (tk.restart)
      begin
         next_cnt = CW'(1);
      end
      else if (cnt == LAST)
      begin
         next_cnt = '0;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt <= '0;
         tk.tick <= 1'b0;
      end
      else
      begin
         cnt <= next_cnt;
         tk.tick <= next_tick;
      end
   end

endmodule

// ===== core/slbs_sequencer.sv
// status LED blink sequencer: picks a condition and drives a two-colour LED
// assumes firmware requests arrive asynchronously; LED lines are active high
// Functional notes
// R1: in the working state the LED stays steadily lit in the primary colour.
// R2: the working-state light is on by default and a setting can turn it off.
// R3: in suspend the alternate colour blinks a quarter second lit, a quarter dark, forever.
// R4: that suspend blink is the default and a setting selects another suspend indication.
// R5: in low-power ready mode the primary colour blinks one second lit, one second dark.
// R6: an update starts dark, then alternates half a second lit and dark until it completes.
// R7: a memory error gives three one-second lit/dark cycles and a 2.5 s dark pause, until power off.
// R8: a thermal warning blinks a quarter second lit and dark and stops after 16 blinks in 8 s.
// R9: firmware commands the blink pattern of any recoverable startup self-test error; the sequencer has no input for a firmware-chosen pattern.
// R10: error patterns beat update, ready and state indications, and a new pattern starts at its first phase.
module slbs_sequencer #(
   parameter int unsigned TICK_CYCLES = slbs_pkg::TICK_CYCLES
)
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // condition requests from firmware
   input wire logic req_s0,
   input wire logic req_s3,
   input wire logic req_ready,
   input wire logic upd_start,
   input wire logic upd_done,
   input wire logic mem_err,
   input wire logic therm_warn,
   // setup options
   input wire logic cfg_s0_disable,
   input wire logic cfg_s3_steady,
   // LED drive
   output logic led_primary,
   output logic led_alternate
);

   localparam int unsigned NIN = 9;

   logic [NIN-1:0] raw_in;
   logic [NIN-1:0] sync1;
   logic [NIN-1:0] sync2;
   logic [NIN-1:0] sync3;
   logic s0_s, s3_s, rdy_s, upd_start_s, upd_done_s, mem_s, therm_s, s0_off, s3_steady;
   logic upd_rise, therm_rise;

   slbs_pkg::slbs_mode_t mode, next_mode;
   slbs_pkg::slbs_pos_t pos, next_pos, period;
   logic mem_hold, next_mem_hold;
   logic upd_act, next_upd_act;
   logic therm_act, next_therm_act;
   logic therm_done;
   logic next_led_primary, next_led_alternate;

   slbs_tick_if tk();

   slbs_prescaler #(
      .TICK_CYCLES(TICK_CYCLES)
   ) slbs_prescaler_inst (
      .clk(clk),
      .resetn(resetn),
      .tk(tk)
   );

   assign raw_in = {cfg_s3_steady, cfg_s0_disable, therm_warn, mem_err, upd_done, upd_start,
                    req_ready, req_s3, req_s0};

   // two-stage synchroniser per input, third stage only for edge detection
   for (genvar i = 0; i < NIN; i++)
   begin : g_sync
      always_ff @(posedge clk or negedge resetn)
      begin
         if (!resetn)
         begin
            sync1[i] <= 1'b0;
            sync2[i] <= 1'b0;
            sync3[i] <= 1'b0;
         end
         else
         begin
            sync1[i] <= raw_in[i];
            sync2[i] <= sync1[i];
            sync3[i] <= sync2[i];
         end
      end
   end

   assign {s3_steady, s0_off, therm_s, mem_s, upd_done_s, upd_start_s, rdy_s, s3_s, s0_s} = sync2;
   assign upd_rise = sync2[3] & ~sync3[3];
   assign therm_rise = sync2[6] & ~sync3[6];
   assign therm_done = (mode == slbs_pkg::M_THERM) && tk.tick && (pos == slbs_pkg::THERM_TICKS - 6'h01);

   // sticky conditions; a new request wins over its clear in the same cycle
   always_comb
   begin
      next_mem_hold = mem_hold | mem_s; // R7
      next_upd_act = upd_rise | (upd_act & ~upd_done_s); // R6
      next_therm_act = therm_rise | (therm_act & ~therm_done); // R8
   end

   // condition priority: errors first, then update, ready, suspend, working
   always_comb
   begin
      if (mem_hold)
         next_mode = slbs_pkg::M_MEM; // R10
      else if (therm_act && !therm_done) // hand over on the last tick, no stray lit cycle
         next_mode = slbs_pkg::M_THERM; // R10
      else if (upd_act)
         next_mode = slbs_pkg::M_UPD;
      else if (rdy_s)
         next_mode = slbs_pkg::M_RDY;
      else if (s3_s)
         next_mode = slbs_pkg::M_S3;
      else if (s0_s)
         next_mode = slbs_pkg::M_S0;
      else
         next_mode = slbs_pkg::M_OFF;
   end

   // a change of pattern restarts the prescaler so the first phase is full length
   assign tk.restart = (next_mode != mode); // R10

   // pattern length per condition, in ticks
   always_comb
   begin
      case (mode)
         slbs_pkg::M_S3: period = 6'(2 * slbs_pkg::S3_HALF);
         slbs_pkg::M_RDY: period = 6'(2 * slbs_pkg::RDY_HALF);
         slbs_pkg::M_UPD: period = 6'(2 * slbs_pkg::UPD_HALF);
         slbs_pkg::M_MEM: period = slbs_pkg::MEM_PERIOD;
         slbs_pkg::M_THERM: period = slbs_pkg::THERM_TICKS;
         default: period = 6'h01;
      endcase
   end

   // position within the pattern
   always_comb
   begin
      next_pos = pos;
      if (tk.restart)
         next_pos = '0; // R10
      else if (tk.tick)
         next_pos = (pos == period - 6'h01) ? 6'h00 : pos + 6'h01;
   end

   // LED levels for the current condition and position
   always_comb
   begin
      next_led_primary = 1'b0;
      next_led_alternate = 1'b0;
      case (mode)
         slbs_pkg::M_S0: next_led_primary = ~s0_off; // R1 R2
         slbs_pkg::M_S3:
         begin
            // the option swaps the blink for a steady alternate light
            next_led_alternate = s3_steady | (pos < slbs_pkg::S3_HALF); // R3 R4
         end
         slbs_pkg::M_RDY: next_led_primary = (pos < slbs_pkg::RDY_HALF); // R5
         slbs_pkg::M_UPD: next_led_primary = (pos >= slbs_pkg::UPD_HALF); // R6
         slbs_pkg::M_MEM:
         begin
            // lit in the first half of each blink slot, dark through the pause
            next_led_primary = (pos < slbs_pkg::MEM_BURST) && ((pos % (2 * slbs_pkg::MEM_HALF)) < slbs_pkg::MEM_HALF); // R7
         end
         slbs_pkg::M_THERM: next_led_primary = ((pos % (2 * slbs_pkg::THERM_HALF)) < slbs_pkg::THERM_HALF); // R8
         default:
         begin
            next_led_primary = 1'b0;
            next_led_alternate = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         mode <= slbs_pkg::M_OFF;
         pos <= '0;
         mem_hold <= 1'b0;
         upd_act <= 1'b0;
         therm_act <= 1'b0;
         led_primary <= 1'b0;
         led_alternate <= 1'b0;
      end
      else
      begin
         mode <= next_mode;
         pos <= next_pos;
         mem_hold <= next_mem_hold;
         upd_act <= next_upd_act;
         therm_act <= next_therm_act;
         led_primary <= next_led_primary;
         led_alternate <= next_led_alternate;
      end
   end

   // checks on the sequencer outputs and on its internal mode, position and sticky state
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   chk_s0_steady_on: assert property ( // R1
      (mode == slbs_pkg::M_S0 && !s0_off)[*2] |=> led_primary && !led_alternate && $past(led_primary))
      else $error("working state light not steady");

   chk_s0_disable_off: assert property ( // R2
      (mode == slbs_pkg::M_S0 && s0_off) |=> !led_primary && !led_alternate)
      else $error("working state light shown while disabled");

   chk_s3_blink_phase: assert property ( // R3
      (mode == slbs_pkg::M_S3 && !s3_steady) |=> (led_alternate == ($past(pos) < slbs_pkg::S3_HALF)) && !led_primary)
      else $error("suspend blink phase wrong");

   chk_s3_option_steady: assert property ( // R4
      (mode == slbs_pkg::M_S3 && s3_steady) |=> led_alternate && !led_primary)
      else $error("suspend option not honoured");

   chk_ready_blink_phase: assert property ( // R5
      (mode == slbs_pkg::M_RDY) |=> led_primary == ($past(pos) < slbs_pkg::RDY_HALF))
      else $error("ready mode blink phase wrong");

   chk_upd_dark_first: assert property ( // R6
      ($rose(mode == slbs_pkg::M_UPD)) |-> pos == 6'h00 ##1 !led_primary)
      else $error("update pattern did not start dark");

   chk_mem_pause_dark: assert property ( // R7
      (mode == slbs_pkg::M_MEM && pos >= slbs_pkg::MEM_BURST) |=> !led_primary && !led_alternate)
      else $error("memory error pause not dark");

   chk_mem_wrap_len: assert property ( // R7
      (mode == slbs_pkg::M_MEM && tk.tick && !tk.restart && pos == slbs_pkg::MEM_PERIOD - 6'h01) |=> pos == 6'h00)
      else $error("memory error pattern length wrong");

   chk_therm_burst_end: assert property ( // R8
      (therm_done && !therm_rise) |=> !therm_act ##1 mode != slbs_pkg::M_THERM)
      else $error("thermal burst did not stop after sixteen blinks");

   chk_error_priority: assert property ( // R10
      mem_hold |=> mode == slbs_pkg::M_MEM)
      else $error("memory error pattern not given priority");

   chk_new_pattern_start: assert property ( // R10
      (mode != $past(mode)) |-> pos == 6'h00)
      else $error("new pattern did not start at its first phase");

   cov_mem_pause: cover property (mode == slbs_pkg::M_MEM && pos == slbs_pkg::MEM_BURST);
   cov_therm_done: cover property (therm_done);
   cov_upd_complete: cover property (upd_act ##1 !upd_act);
   cov_s3_blink: cover property (mode == slbs_pkg::M_S3 && led_alternate ##1 !led_alternate);

endmodule

// ===== sim/slbs_led_model.sv
// front-panel two-colour LED seen by the sequencer
// assumes LED lines are active high and change only on clk
module slbs_led_model
(
   // clock
   input wire logic clk,
   // LED lines
   input wire logic led_primary,
   input wire logic led_alternate,
   // observation
   output int blinks_p,
   output int blinks_a
);
   timeunit 1ns;
   timeprecision 1ns;
   logic prev_p = 1'b0;
   logic prev_a = 1'b0;
   int cnt_p = 0;
   int cnt_a = 0;

   // a blink is one dark-to-lit change; a lit start after reset counts too
   always @(negedge clk)
   begin
      if (led_primary === 1'b1 && prev_p !== 1'b1)
         cnt_p <= cnt_p + 1;
      if (led_alternate === 1'b1 && prev_a !== 1'b1)
         cnt_a <= cnt_a + 1;
      prev_p <= led_primary;
      prev_a <= led_alternate;
   end

   assign blinks_p = cnt_p;
   assign blinks_a = cnt_a;
endmodule

// ===== sim/slbs_sequencer_tb.sv
// self-checking bench for the status LED sequencer, with a short tick
// assumes tick of 4 clocks: every phase length below is in clocks
module slbs_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int T = 4;
   logic clk = 1'b0, resetn = 1'b0;
   logic req_s0 = 1'b0, req_s3 = 1'b0, req_ready = 1'b0, upd_start = 1'b0, upd_done = 1'b0;
   logic mem_err = 1'b0, therm_warn = 1'b0, cfg_s0_disable = 1'b0, cfg_s3_steady = 1'b0;
   logic led_primary, led_alternate;
   int blinks_p, blinks_a, mismatches = 0, num_checks = 0;

   slbs_sequencer #(.TICK_CYCLES(T)) slbs_sequencer_inst (.clk(clk), .resetn(resetn),
      .req_s0(req_s0), .req_s3(req_s3), .req_ready(req_ready), .upd_start(upd_start),
      .upd_done(upd_done), .mem_err(mem_err), .therm_warn(therm_warn),
      .cfg_s0_disable(cfg_s0_disable), .cfg_s3_steady(cfg_s3_steady),
      .led_primary(led_primary), .led_alternate(led_alternate));
   slbs_led_model slbs_led_model_inst (.clk(clk), .led_primary(led_primary),
      .led_alternate(led_alternate), .blinks_p(blinks_p), .blinks_a(blinks_a));

   // 25 MHz
   initial
   begin
      forever #20 clk = ~clk;
   end

   task conclude;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task check(input string what, input int exp, input int got);
      num_checks++;
      if (exp != got)
      begin
         mismatches++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // sample on the falling edge so registered outputs have settled
   task run(input bit alt, input logic lvl, input int lim, output int n);
      n = 0;
      while (((alt ? led_alternate : led_primary) === lvl) && n < lim)
      begin
         n++;
         @(negedge clk);
      end
   endtask

   // bounded wait for a level; running out ends the run as a mismatch
   task wait_for(input bit alt, input logic lvl);
      int k;
      k = 0;
      while ((alt ? led_alternate : led_primary) !== lvl && k < 300)
      begin
         k++;
         @(negedge clk);
      end
      if (k == 300)
      begin
         mismatches++;
         $display("mismatch led wait expected %0d seen %0d", lvl, !lvl);
         conclude();
      end
   endtask

   // bounded wait for a lit phase, then one lit and one dark run
   task measure(input bit alt, output int hi, output int lo);
      wait_for(alt, 1'b1);
      run(alt, 1'b1, 300, hi);
      run(alt, 1'b0, 300, lo);
   endtask

   // request lines held 4 clocks, longer than the synchroniser needs
   task pulse_upd(input bit done);
      @(posedge clk) if (done) upd_done <= 1'b1; else upd_start <= 1'b1;
      repeat (4) @(posedge clk);
      upd_done <= 1'b0;
      upd_start <= 1'b0;
   endtask

   task t_s0;
      int n;
      @(posedge clk) req_s0 <= 1'b1;
      repeat (8) @(negedge clk);
      run(0, 1'b1, 20, n);
      check("s0 primary", 20, n);
      run(1, 1'b0, 20, n);
      check("s0 alternate", 20, n);
      @(posedge clk) cfg_s0_disable <= 1'b1;
      repeat (8) @(negedge clk);
      run(0, 1'b0, 20, n);
      check("s0 disabled", 20, n);
      @(posedge clk) cfg_s0_disable <= 1'b0;
   endtask

   task t_upd;
      int n;
      repeat (8) @(negedge clk);
      pulse_upd(0);
      wait_for(0, 1'b0);
      run(0, 1'b0, 100, n);
      check("upd first dark", 2 * T, n);
      run(0, 1'b1, 100, n);
      check("upd lit", 2 * T, n);
      run(0, 1'b0, 100, n);
      check("upd dark", 2 * T, n);
      pulse_upd(1);
      repeat (8) @(negedge clk);
      run(0, 1'b1, 20, n);
      check("upd done to s0", 20, n);
   endtask

   task t_s3;
      int hi, lo, n;
      @(posedge clk) req_s3 <= 1'b1;
      measure(1, hi, lo);
      check("s3 lit", T, hi);
      check("s3 dark", T, lo);
      run(0, 1'b0, 16, n);
      check("s3 primary", 16, n);
      @(posedge clk) cfg_s3_steady <= 1'b1;
      repeat (8) @(negedge clk);
      run(1, 1'b1, 20, n);
      check("s3 steady", 20, n);
      @(posedge clk) cfg_s3_steady <= 1'b0;
   endtask

   task t_ready;
      int hi, lo, n;
      @(posedge clk) req_ready <= 1'b1;
      measure(0, hi, lo);
      check("ready lit", 4 * T, hi);
      check("ready dark", 4 * T, lo);
      run(1, 1'b0, 32, n);
      check("ready over s3", 32, n);
      @(posedge clk) req_ready <= 1'b0;
   endtask

   task t_therm;
      int hi, lo, b0, n;
      repeat (10) @(negedge clk);
      b0 = blinks_p;
      @(posedge clk) therm_warn <= 1'b1;
      repeat (4) @(posedge clk);
      therm_warn <= 1'b0;
      measure(0, hi, lo);
      check("therm lit", T, hi);
      check("therm dark", T, lo);
      repeat (200) @(negedge clk);
      check("therm blinks", 16, blinks_p - b0);
      run(1, 1'b1, 8, n);
      measure(1, hi, lo);
      check("s3 after burst", T, hi);
   endtask

   // firmware shows the memory fault found at startup self-test
   task t_mem;
      int hi, lo, a0;
      @(posedge clk) req_s3 <= 1'b0;
      cfg_s0_disable <= 1'b1;
      repeat (10) @(negedge clk);
      a0 = blinks_a;
      @(posedge clk) mem_err <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         measure(0, hi, lo);
         check("mem lit", 4 * T, hi);
         check("mem dark", (i == 2) ? 14 * T : 4 * T, lo);
      end
      // the memory code uses the primary colour only
      check("mem alternate blinks", 0, blinks_a - a0);
   endtask

   initial
   begin
      int n;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      run(0, 1'b0, 4, n);
      check("reset dark", 4, n);
      t_s0();
      t_upd();
      t_s3();
      t_ready();
      t_therm();
      t_mem();
      conclude();
   end
endmodule
